/* verilog/scc_top.sv */
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top
  import scc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [`SCC_ADDR_W-1:0] i_addr,
  input wire logic [`SCC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`SCC_DATA_W-1:0] o_rdata,
  input wire logic i_dfc_valid,
  input wire scc_pix_t i_dfc_data,
  input wire logic [`SCC_POS_W-1:0] i_dfc_vpos,
  input wire logic [`SCC_POS_W-1:0] i_dfc_vdefect,
  input wire logic i_dfc_col_hit,
  output logic o_dfc_valid,
  output scc_pix_t o_dfc_data,
  input wire logic i_csc_valid,
  input wire scc_vec_t i_csc_data,
  output logic o_csc_valid,
  output scc_vec_t o_csc_data,
  output logic o_csc_on
);
  logic [`SCC_LVL_W-1:0] lvl_on_ff;
  logic [`SCC_LVL_W-1:0] lvl_above_ff;
  logic [`SCC_LVL_W-1:0] lvl_below_ff;
  logic [`SCC_SHIFT_W-1:0] shift_ff;
  logic [`SCC_DATA_W-1:0] csc_en_ff;
  logic [`SCC_DATA_W-1:0] coef_ff [`SCC_NUM_COEF_REGS];
  logic [`SCC_DATA_W-1:0] nxt_rdata;
  logic [3:0] coef_idx;

  scc_cfg_if cfg ();

  assign coef_idx = i_addr - `SCC_OFS_COEF0;

  // level and shift registers keep only their defined bits
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      lvl_on_ff <= '0;
      lvl_above_ff <= '0;
      lvl_below_ff <= '0;
      shift_ff <= '0;
    end
    else if (i_wr)
    begin
      if (i_addr == `SCC_OFS_LVL_ON)
        lvl_on_ff <= i_wdata[`SCC_LVL_MSB:0];
      if (i_addr == `SCC_OFS_LVL_ABOVE)
        lvl_above_ff <= i_wdata[`SCC_LVL_MSB:0];
      if (i_addr == `SCC_OFS_LVL_BELOW)
        lvl_below_ff <= i_wdata[`SCC_LVL_MSB:0];
      if (i_addr == `SCC_OFS_SHIFT)
        shift_ff <= i_wdata[`SCC_SHIFT_MSB:0];
    end
  end

  // the whole 16-bit word is the enable field, so it is kept intact
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      csc_en_ff <= `SCC_RESET_VAL;
    else if (i_wr && i_addr == `SCC_OFS_CSC_EN)
      csc_en_ff <= i_wdata;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_csc_on <= 1'b0;
    else
      o_csc_on <= (csc_en_ff == `SCC_CSC_ON_VAL);
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int k = 0; k < `SCC_NUM_COEF_REGS; k++)
        coef_ff[k] <= `SCC_RESET_VAL;
    end
    else if (i_wr && i_addr >= `SCC_OFS_COEF0 && i_addr <= `SCC_OFS_COEF7)
      coef_ff[coef_idx[2:0]] <= i_wdata;
  end

  always_comb
  begin
    for (int k = 0; k < `SCC_NUM_COEF_REGS; k++)
    begin
      cfg.matrix[k/2][(k%2)*2] = coef_ff[k][`SCC_COEF_LO_MSB:`SCC_COEF_LO_LSB];
      cfg.matrix[k/2][(k%2)*2+1] = coef_ff[k][`SCC_COEF_HI_MSB:`SCC_COEF_HI_LSB];
    end
  end

  assign cfg.lvl_on = lvl_on_ff;
  assign cfg.lvl_above = lvl_above_ff;
  assign cfg.lvl_below = lvl_below_ff;
  assign cfg.lvl_shift = shift_ff;
  assign cfg.csc_on = (csc_en_ff == `SCC_CSC_ON_VAL);

  always_comb
  begin
    nxt_rdata = '0;
    if (i_addr == `SCC_OFS_LVL_ON)
      nxt_rdata = {8'h00, lvl_on_ff};
    else if (i_addr == `SCC_OFS_LVL_ABOVE)
      nxt_rdata = {8'h00, lvl_above_ff};
    else if (i_addr == `SCC_OFS_LVL_BELOW)
      nxt_rdata = {8'h00, lvl_below_ff};
    else if (i_addr == `SCC_OFS_SHIFT)
      nxt_rdata = {13'h0000, shift_ff};
    else if (i_addr == `SCC_OFS_CSC_EN)
      nxt_rdata = csc_en_ff;
    else if (i_addr >= `SCC_OFS_COEF0 && i_addr <= `SCC_OFS_COEF7)
      nxt_rdata = coef_ff[coef_idx[2:0]];
    else if (i_addr == `SCC_OFS_STATUS)
      nxt_rdata = {13'h0000, cfg.last_pos, cfg.csc_on};
  end

  // read data stand for exactly one cycle; idle cycles return zero
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= '0;
    else if (i_rd)
      o_rdata <= nxt_rdata;
    else
      o_rdata <= '0;
  end

  scc_defect_sub u_dfc (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .cfg(cfg.dfc),
    .i_valid(i_dfc_valid),
    .i_data(i_dfc_data),
    .i_vpos(i_dfc_vpos),
    .i_vdefect(i_dfc_vdefect),
    .i_col_hit(i_dfc_col_hit),
    .o_valid(o_dfc_valid),
    .o_data(o_dfc_data)
  );

  scc_csc u_csc (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .cfg(cfg.csc),
    .i_valid(i_csc_valid),
    .i_data(i_csc_data),
    .o_valid(o_csc_valid),
    .o_data(o_csc_data)
  );
endmodule

/* verilog/scc_regs.svh */
// Operation
// - below-line defect level is an 8-bit field in the low byte
// - defect level is left-shifted by the shift setting, then subtracted from pixel
// - converter runs when enable field equals 1, bypassed when it is 0
// - each matrix coefficient is signed 8-bit with 5 fractional bits
// - even column coefficient in low byte, odd column in high byte
// - sixteen coefficients map row by row onto eight consecutive registers
// - on-line and above-line levels selected by row, shifted and subtracted alike
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

`define SCC_ADDR_W 4
`define SCC_DATA_W 16
`define SCC_PIX_W 14
`define SCC_POS_W 12
`define SCC_COMP_W 10
`define SCC_LVL_W 8
`define SCC_SHIFT_W 3
`define SCC_ACC_W 21

`define SCC_OFS_LVL_ON 4'h0
`define SCC_OFS_LVL_ABOVE 4'h1
`define SCC_OFS_LVL_BELOW 4'h2
`define SCC_OFS_SHIFT 4'h3
`define SCC_OFS_CSC_EN 4'h4
`define SCC_OFS_COEF0 4'h5
`define SCC_OFS_COEF7 4'hC
`define SCC_OFS_STATUS 4'hD

`define SCC_NUM_COEF_REGS 8
`define SCC_RESET_VAL 16'h0000
`define SCC_CSC_ON_VAL 16'h0001

`define SCC_LVL_MSB 7
`define SCC_SHIFT_MSB 2
`define SCC_COEF_LO_MSB 7
`define SCC_COEF_LO_LSB 0
`define SCC_COEF_HI_MSB 15
`define SCC_COEF_HI_LSB 8

`define SCC_COEF_FRAC 5
`define SCC_ROUND_HALF 21'sh10
`define SCC_COMP_MAX 21'sh3FF

`endif

/* verilog/scc_pkg.sv */
package scc_pkg;
  `include "scc_regs.svh"

  typedef logic [`SCC_LVL_W-1:0] scc_coef_t;
  typedef scc_coef_t [3:0] scc_row_t;
  typedef scc_row_t [3:0] scc_matrix_t;
  typedef logic [`SCC_COMP_W-1:0] scc_comp_t;
  typedef scc_comp_t [3:0] scc_vec_t;
  typedef logic [`SCC_PIX_W-1:0] scc_pix_t;
  typedef enum logic [1:0] {SCC_ROW_ABOVE, SCC_ROW_ON, SCC_ROW_BELOW} scc_row_pos_t;
endpackage

/* verilog/scc_cfg_if.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
interface scc_cfg_if;
  import scc_pkg::*;
  logic [`SCC_LVL_W-1:0] lvl_on;
  logic [`SCC_LVL_W-1:0] lvl_above;
  logic [`SCC_LVL_W-1:0] lvl_below;
  logic [`SCC_SHIFT_W-1:0] lvl_shift;
  logic csc_on;
  scc_matrix_t matrix;
  scc_row_pos_t last_pos;

  modport src (output lvl_on, output lvl_above, output lvl_below, output lvl_shift, output csc_on,
               output matrix, input last_pos);
  modport dfc (input lvl_on, input lvl_above, input lvl_below, input lvl_shift, output last_pos);
  modport csc (input csc_on, input matrix);
endinterface

/* verilog/scc_defect_sub.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_defect_sub
  import scc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  scc_cfg_if.dfc cfg,
  input wire logic i_valid,
  input wire scc_pix_t i_data,
  input wire logic [`SCC_POS_W-1:0] i_vpos,
  input wire logic [`SCC_POS_W-1:0] i_vdefect,
  input wire logic i_col_hit,
  output logic o_valid,
  output scc_pix_t o_data
);
  scc_row_pos_t pos;
  logic [`SCC_LVL_W-1:0] lvl;
  logic [`SCC_PIX_W:0] sub;
  logic [`SCC_PIX_W:0] diff;
  scc_pix_t nxt_data;
  scc_row_pos_t pos_ff;

  always_comb
  begin
    if (i_vpos == i_vdefect)
    begin
      pos = SCC_ROW_ON;
      lvl = cfg.lvl_on;
    end
    else if (i_vpos < i_vdefect)
    begin
      pos = SCC_ROW_ABOVE;
      lvl = cfg.lvl_above;
    end
    else
    begin
      pos = SCC_ROW_BELOW;
      lvl = cfg.lvl_below;
    end
    sub = ({{(`SCC_PIX_W+1-`SCC_LVL_W){1'b0}}, lvl}) << cfg.lvl_shift;
    diff = {1'b0, i_data} - sub;
    // clamp at black so a large level cannot wrap to white, unless at shift 7 the shifted level exceeds the pixel by more than 16384
    if (!i_col_hit)
      nxt_data = i_data;
    else if (diff[`SCC_PIX_W])
      nxt_data = '0;
    else
      nxt_data = diff[`SCC_PIX_W-1:0];
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_valid <= 1'b0;
      o_data <= '0;
    end
    else
    begin
      o_valid <= i_valid;
      if (i_valid)
        o_data <= nxt_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pos_ff <= SCC_ROW_ABOVE;
    else if (i_valid && i_col_hit)
      pos_ff <= pos;
  end

  assign cfg.last_pos = pos_ff;
endmodule

/* verilog/scc_csc.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_csc
  import scc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  scc_cfg_if.csc cfg,
  input wire logic i_valid,
  input wire scc_vec_t i_data,
  output logic o_valid,
  output scc_vec_t o_data
);
  function automatic scc_comp_t round_sat(input logic signed [`SCC_ACC_W-1:0] acc);
    logic signed [`SCC_ACC_W-1:0] r;
    r = (acc + `SCC_ROUND_HALF) >>> `SCC_COEF_FRAC;
    if (r < 0)
      return '0;
    else if (r > `SCC_COMP_MAX)
      return '1;
    else
      return r[`SCC_COMP_W-1:0];
  endfunction

  scc_vec_t nxt_data;

  always_comb
  begin
    logic signed [`SCC_ACC_W-1:0] acc;
    acc = '0;
    for (int r = 0; r < 4; r++)
    begin
      acc = '0;
      for (int c = 0; c < 4; c++)
        // operands widened to the accumulator first so the product is never cut; unsigned component, signed coef
        acc = acc + (`SCC_ACC_W'(signed'({1'b0, i_data[c]})) * `SCC_ACC_W'(signed'(cfg.matrix[r][c])));
      nxt_data[r] = cfg.csc_on ? round_sat(acc) : i_data[r];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_valid <= 1'b0;
      o_data <= '0;
    end
    else
    begin
      o_valid <= i_valid;
      if (i_valid)
        o_data <= nxt_data;
    end
  end
endmodule

/* test/scc_top_monitor.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top_mon
  import scc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [`SCC_ADDR_W-1:0] i_addr,
  input wire logic [`SCC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [`SCC_DATA_W-1:0] o_rdata,
  input wire logic i_dfc_valid,
  input wire scc_pix_t i_dfc_data,
  input wire logic i_dfc_col_hit,
  input wire logic o_dfc_valid,
  input wire scc_pix_t o_dfc_data,
  input wire logic i_csc_valid,
  input wire scc_vec_t i_csc_data,
  input wire logic o_csc_valid,
  input wire scc_vec_t o_csc_data,
  input wire logic o_csc_on
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  property p_on;
    i_wr && i_addr == `SCC_OFS_CSC_EN && i_wdata == 16'h0001 |=> ##1 o_csc_on;
  endproperty
  property p_off;
    i_wr && i_addr == `SCC_OFS_CSC_EN && i_wdata != 16'h0001 |=> ##1 !o_csc_on;
  endproperty
  // the register may change one edge before the flag follows, so skip that cycle
  property p_byp;
    i_csc_valid && !o_csc_on && !$past(i_wr) |=> o_csc_data == $past(i_csc_data);
  endproperty
  property p_cv;
    i_csc_valid |=> o_csc_valid;
  endproperty
  property p_dv;
    i_dfc_valid |=> o_dfc_valid;
  endproperty
  property p_sub;
    i_dfc_valid |=> o_dfc_data <= $past(i_dfc_data);
  endproperty
  property p_nohit;
    i_dfc_valid && !i_dfc_col_hit |=> o_dfc_data == $past(i_dfc_data);
  endproperty
  property p_rsv;
    i_rd && i_addr == `SCC_OFS_LVL_BELOW |=> o_rdata[15:8] == 8'h00;
  endproperty
  a_on: assert property (p_on) else $error("converter flag did not rise");
  a_off: assert property (p_off) else $error("converter flag did not fall");
  a_byp: assert property (p_byp) else $error("bypass data altered");
  a_cv: assert property (p_cv) else $error("converter valid missing");
  a_dv: assert property (p_dv) else $error("defect valid missing");
  a_sub: assert property (p_sub) else $error("defect output above input");
  a_nohit: assert property (p_nohit) else $error("pixel off column altered");
  a_rsv: assert property (p_rsv) else $error("level upper byte not zero");
  c_en: cover property (i_wr && i_addr == `SCC_OFS_CSC_EN);
  c_conv: cover property (o_csc_on && o_csc_valid);
  c_clamp: cover property (o_dfc_valid && o_dfc_data == 14'h0000);
endmodule

/* test/scc_top_tb.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top_tb;
  import scc_pkg::*;
  logic i_ref_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic [`SCC_ADDR_W-1:0] i_addr = 4'h0;
  logic [`SCC_DATA_W-1:0] i_wdata = 16'h0000;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [`SCC_DATA_W-1:0] o_rdata;
  logic i_dfc_valid = 1'h0;
  scc_pix_t i_dfc_data = 14'h0000;
  logic [`SCC_POS_W-1:0] i_dfc_vpos = 12'h000;
  logic [`SCC_POS_W-1:0] i_dfc_vdefect = 12'h064;
  logic i_dfc_col_hit = 1'h0;
  logic o_dfc_valid;
  scc_pix_t o_dfc_data;
  logic i_csc_valid = 1'h0;
  scc_vec_t i_csc_data = 40'h0000000000;
  logic o_csc_valid;
  scc_vec_t o_csc_data;
  logic o_csc_on;
  int fail_count = 0;
  int cmp_count = 0;
  // one register per pair of coefficients: the -0.5 weight sits in row 0 column 0
  logic [15:0] coefs [8] = '{16'h00F0, 16'h2000, 16'h0000, 16'h0020, 16'h2000, 16'h0000, 16'h0020, 16'h0000};

  scc_top i_scc_top(.i_ref_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_dfc_valid,
    .i_dfc_data, .i_dfc_vpos, .i_dfc_vdefect, .i_dfc_col_hit, .o_dfc_valid, .o_dfc_data, .i_csc_valid,
    .i_csc_data, .o_csc_valid, .o_csc_data, .o_csc_on);

  initial
  begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1;
    chk(40'(o_rdata), 40'(e));
  endtask

  task automatic px(input scc_pix_t d, input logic [11:0] v, input logic h, input scc_pix_t e);
    @(posedge i_ref_clk);
    i_dfc_valid <= 1'h1;
    i_dfc_data <= d;
    i_dfc_vpos <= v;
    i_dfc_col_hit <= h;
    @(posedge i_ref_clk);
    i_dfc_valid <= 1'h0;
    #1;
    chk(40'(o_dfc_data), 40'(e));
    chk(40'(o_dfc_valid), 40'h0000000001);
  endtask

  task automatic cv(input scc_vec_t d, input scc_vec_t e);
    @(posedge i_ref_clk);
    i_csc_valid <= 1'h1;
    i_csc_data <= d;
    @(posedge i_ref_clk);
    i_csc_valid <= 1'h0;
    #1;
    chk(o_csc_data, e);
    chk(40'(o_csc_valid), 40'h0000000001);
  endtask

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'h1;
    for (int k = 0; k < 16; k++)
      rd(4'(k), 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    wr(`SCC_OFS_LVL_ON, 16'h0010);
    wr(`SCC_OFS_LVL_ABOVE, 16'h0020);
    wr(`SCC_OFS_LVL_BELOW, 16'hFF30);
    wr(`SCC_OFS_SHIFT, 16'h0002);
    rd(`SCC_OFS_LVL_BELOW, 16'h0030);
    // read data must fall back to zero one cycle after it was shown
    @(posedge i_ref_clk);
    #1;
    chk(40'(o_rdata), 40'h0000000000);
    rd(`SCC_OFS_SHIFT, 16'h0002);
    px(14'h03E8, 12'h0C8, 1'h1, 14'h0328);
    px(14'h03E8, 12'h064, 1'h1, 14'h03A8);
    px(14'h03E8, 12'h010, 1'h1, 14'h0368);
    px(14'h03E8, 12'h0C8, 1'h0, 14'h03E8);
    px(14'h0032, 12'h0C8, 1'h1, 14'h0000);
    // last pixel on the defect column was below the line, converter still off
    rd(`SCC_OFS_STATUS, 16'h0004);
    for (int k = 0; k < 8; k++)
      wr(4'(`SCC_OFS_COEF0 + k), coefs[k]);
    for (int k = 0; k < 8; k++)
      rd(4'(`SCC_OFS_COEF0 + k), coefs[k]);
    wr(`SCC_OFS_CSC_EN, 16'h0003);
    @(posedge i_ref_clk);
    #1;
    chk(40'(o_csc_on), 40'h0000000000);
    cv({10'h190, 10'h12C, 10'h0C8, 10'h064}, {10'h190, 10'h12C, 10'h0C8, 10'h064});
    wr(`SCC_OFS_CSC_EN, 16'h0001);
    @(posedge i_ref_clk);
    #1;
    chk(40'(o_csc_on), 40'h0000000001);
    rd(`SCC_OFS_STATUS, 16'h0005);
    cv({10'h190, 10'h12C, 10'h0C8, 10'h064}, {10'h064, 10'h0C8, 10'h12C, 10'h15E});
    cv({10'h000, 10'h12C, 10'h0C8, 10'h3E8}, {10'h3E8, 10'h0C8, 10'h12C, 10'h000});
    // gain of two on row 1 column 2 drives output 1 past full scale
    wr(4'(`SCC_OFS_COEF0 + 3), 16'h0040);
    cv({10'h000, 10'h258, 10'h000, 10'h000}, {10'h000, 10'h000, 10'h3FF, 10'h000});
    wrap_up();
  end

  // the full sequence needs about 120 cycles
  initial
  begin
    repeat (3000) @(posedge i_ref_clk);
    fail_count++;
    wrap_up();
  end
endmodule

bind scc_top scc_top_mon i_scc_top_mon(.i_ref_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_dfc_valid, .i_dfc_data, .i_dfc_col_hit, .o_dfc_valid, .o_dfc_data, .i_csc_valid, .i_csc_data,
  .o_csc_valid, .o_csc_data, .o_csc_on);
